/* File: rtl/rsq_defs.vh */
// Constants for the reset sequencer and reset cause log.
// Assumes the 125 MHz reference clock, APB with 32-bit data.
`ifndef RSQ_DEFS_VH
`define RSQ_DEFS_VH

// ------------------------------------------------------------
// APB register map (byte addresses)
// ------------------------------------------------------------
`define RSQ_OFS_CAUSE    12'h000
`define RSQ_OFS_CONFIG   12'h004
`define RSQ_OFS_STATUS   12'h008

// ------------------------------------------------------------
// Reset cause register fields
// ------------------------------------------------------------
`define RSQ_FLAGS_W      8
`define RSQ_B_POWER_ON   7
`define RSQ_B_EXT_PIN    6
`define RSQ_B_WATCHDOG   5
`define RSQ_B_BAD_OP     4
`define RSQ_B_BAD_FETCH  3
`define RSQ_B_MONITOR    2
`define RSQ_B_LOW_SUP    1
`define RSQ_CAUSE_RST    8'h80
`define RSQ_CAUSE_POR    8'h80

// ------------------------------------------------------------
// First config register fields
// ------------------------------------------------------------
`define RSQ_B_STOP_EN    0
`define RSQ_STOP_EN_RST  1'b0

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define RSQ_ST_MSB       3
`define RSQ_B_PIN_LVL    4
`define RSQ_B_CORE_RST   5
`define RSQ_B_LSUP_LVL   6

// ------------------------------------------------------------
// Timing in reference-clock cycles
// ------------------------------------------------------------
`define RSQ_CNT_W        13
`define RSQ_STAB_CYC     13'h1000
`define RSQ_PIN_CYC      13'h0020
`define RSQ_POST_CYC     13'h0020

// ------------------------------------------------------------
// Memory locations
// ------------------------------------------------------------
`define RSQ_VEC_HI_ADDR  16'hFFFE
`define RSQ_VEC_LO_ADDR  16'hFFFF
`define RSQ_WDOG_ADDR    16'hFFFF

`endif

/* File: rtl/rsq_top.v */
// Reset sequencer and reset cause log with an APB register slave.
// Assumes core event inputs on ref_clk_i; pin and supply inputs are
// asynchronous; vec_data_i is valid in the cycle vec_rd_o is high.
`timescale 1ns/10ps
`include "rsq_defs.vh"

module rsq_top (
   // Clock, reset, enable
   input  wire        ref_clk_i,
   input  wire        srst_i,
   input  wire        clk_en_i,
   // APB slave
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   // Open-drain reset pin
   input  wire        rst_pin_i,
   output reg         rst_pin_o,
   output reg         rst_pin_oe_o,
   // Supply monitors, asynchronous
   input  wire        power_on_pulse_i,
   input  wire        low_supply_i,
   // Reset requests from the core
   input  wire        wdog_overflow_i,
   input  wire        bad_opcode_i,
   input  wire        stop_exec_i,
   input  wire        fetch_unmapped_i,
   input  wire        fetch_is_opcode_i,
   input  wire        monitor_entry_i,
   // Core bus watch for watchdog clear
   input  wire        cpu_wr_i,
   input  wire [15:0] cpu_addr_i,
   output reg         wdog_clear_o,
   // Core control and vector fetch
   input  wire [7:0]  vec_data_i,
   output reg         cpu_reset_o,
   output reg         clocks_hold_o,
   output reg         bus_div4_sel_o,
   output reg         vec_rd_o,
   output reg  [15:0] vec_addr_o,
   output reg  [15:0] pc_o,
   output reg         pc_load_o
);

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [3:0] ST_RUN   = 4'h0;
   localparam [3:0] ST_LOW   = 4'h1;
   localparam [3:0] ST_STAB  = 4'h2;
   localparam [3:0] ST_DRIVE = 4'h3;
   localparam [3:0] ST_POST  = 4'h4;
   localparam [3:0] ST_EXT   = 4'h5;
   localparam [3:0] ST_VHI   = 4'h6;
   localparam [3:0] ST_VLO   = 4'h7;
   localparam [3:0] ST_VLD   = 4'h8;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Level changes only once second and third stages agree
   // Stage one is never read here: it may still be metastable
   function filt;
      input s2;
      input s3;
      input old;
      begin
         filt = (s2 == s3) ? s2 : old;
      end
   endfunction

   // Counts run from zero, so the last cycle is the limit minus one
   function last_cyc;
      input [`RSQ_CNT_W-1:0] cnt;
      input [`RSQ_CNT_W-1:0] lim;
      begin
         last_cyc = (cnt == lim - 13'h0001);
      end
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   reg  [2:0]              pin_s_q;
   reg  [2:0]              por_s_q;
   reg  [2:0]              lsup_s_q;
   reg                     pin_lvl_q;
   reg                     por_lvl_q;
   reg                     lsup_lvl_q;
   reg  [3:0]              st_q;
   reg  [3:0]              st_d;
   reg  [`RSQ_CNT_W-1:0]   cnt_q;
   reg  [`RSQ_CNT_W-1:0]   cnt_d;
   reg  [`RSQ_FLAGS_W-1:0] flags_q;
   reg  [`RSQ_FLAGS_W-1:0] flags_d;
   reg  [`RSQ_FLAGS_W-1:0] set_d;
   reg                     por_ev;
   reg                     stop_en_q;
   reg                     drive_d;
   reg                     cpu_rst_d;
   reg                     hold_d;
   reg                     vec_rd_d;
   reg  [15:0]             vec_addr_d;
   reg  [15:0]             pc_d;
   reg                     pc_ld_d;
   reg                     int_req;
   reg  [31:0]             rdata_d;
   reg                     err_d;
   wire                    apb_acc;
   wire                    apb_done;
   wire                    rd_clear;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   // Two-cycle access phase: pready is registered
   // Read data is latched in the first access cycle
   assign apb_acc  = psel_i & penable_i & ~pready_o;
   assign apb_done = psel_i & penable_i & pready_o;
   assign rd_clear = apb_done & ~pwrite_i & (paddr_i == `RSQ_OFS_CAUSE);

   always @* begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      if (paddr_i == `RSQ_OFS_CAUSE) begin
         rdata_d[`RSQ_FLAGS_W-1:0] = flags_q;
      end else if (paddr_i == `RSQ_OFS_CONFIG) begin
         rdata_d[`RSQ_B_STOP_EN] = stop_en_q;
      end else if (paddr_i == `RSQ_OFS_STATUS) begin
         rdata_d[`RSQ_ST_MSB:0]     = st_q;
         rdata_d[`RSQ_B_PIN_LVL]  = pin_lvl_q;
         rdata_d[`RSQ_B_CORE_RST] = cpu_reset_o;
         rdata_d[`RSQ_B_LSUP_LVL] = lsup_lvl_q;
      end else begin
         err_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Internal reset requests from the core
   // ------------------------------------------------------------
   // Data reads of unmapped space are excluded by the opcode qualifier
   always @* begin
      int_req = wdog_overflow_i | bad_opcode_i | monitor_entry_i
              | (stop_exec_i & ~stop_en_q)
              | (fetch_unmapped_i & fetch_is_opcode_i);
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Power-on beats low supply, which beats the running sequence
   always @* begin
      st_d       = st_q;
      cnt_d      = cnt_q + 13'h0001;
      set_d      = {`RSQ_FLAGS_W{1'b0}};
      por_ev     = 1'b0;
      drive_d    = 1'b0;
      cpu_rst_d  = 1'b1;
      hold_d     = 1'b0;
      vec_rd_d   = 1'b0;
      vec_addr_d = vec_addr_o;
      pc_d       = pc_o;
      pc_ld_d    = 1'b0;
      if (por_lvl_q) begin
         // Counter restarts while the pulse lasts
         por_ev  = 1'b1;
         st_d    = ST_STAB;
         cnt_d   = {`RSQ_CNT_W{1'b0}};
         drive_d = 1'b1;
         hold_d  = 1'b1;
      end else if (lsup_lvl_q && st_q != ST_LOW) begin
         st_d    = ST_LOW;
         set_d[`RSQ_B_LOW_SUP] = 1'b1;
         drive_d = 1'b1;
         hold_d  = 1'b1;
      end else begin
         case (st_q)
            ST_RUN: begin
               cpu_rst_d = 1'b0;
               if (int_req) begin
                  st_d      = ST_DRIVE;
                  cnt_d     = {`RSQ_CNT_W{1'b0}};
                  cpu_rst_d = 1'b1;
                  drive_d   = 1'b1;
                  set_d[`RSQ_B_WATCHDOG]  = wdog_overflow_i;
                  set_d[`RSQ_B_BAD_OP]    = bad_opcode_i
                                          | (stop_exec_i & ~stop_en_q);
                  set_d[`RSQ_B_BAD_FETCH] = fetch_unmapped_i
                                          & fetch_is_opcode_i;
                  set_d[`RSQ_B_MONITOR]   = monitor_entry_i;
               end else if (!pin_lvl_q) begin
                  st_d      = ST_EXT;
                  cpu_rst_d = 1'b1;
                  set_d[`RSQ_B_EXT_PIN] = 1'b1;
               end
            end
            ST_LOW: begin
               drive_d = 1'b1;
               hold_d  = 1'b1;
               cnt_d   = {`RSQ_CNT_W{1'b0}};
               if (!lsup_lvl_q) begin
                  st_d = ST_STAB;
               end
            end
            ST_STAB: begin
               drive_d = 1'b1;
               hold_d  = 1'b1;
               if (last_cyc(cnt_q, `RSQ_STAB_CYC)) begin
                  st_d   = ST_DRIVE;
                  cnt_d  = {`RSQ_CNT_W{1'b0}};
                  hold_d = 1'b0;
               end
            end
            ST_DRIVE: begin
               drive_d = 1'b1;
               if (last_cyc(cnt_q, `RSQ_PIN_CYC)) begin
                  st_d    = ST_POST;
                  cnt_d   = {`RSQ_CNT_W{1'b0}};
                  drive_d = 1'b0;
               end
            end
            ST_POST: begin
               // Own drive still echoes here, so external detect waits for the last cycle
               if (last_cyc(cnt_q, `RSQ_POST_CYC)) begin
                  st_d = ST_VHI;
                  set_d[`RSQ_B_EXT_PIN] = ~pin_lvl_q;
               end
            end
            ST_EXT: begin
               if (pin_lvl_q) begin
                  st_d = ST_VHI;
               end
            end
            ST_VHI: begin
               vec_rd_d   = 1'b1;
               vec_addr_d = `RSQ_VEC_HI_ADDR;
               st_d       = ST_VLO;
            end
            ST_VLO: begin
               pc_d[15:8] = vec_data_i;
               vec_rd_d   = 1'b1;
               vec_addr_d = `RSQ_VEC_LO_ADDR;
               st_d       = ST_VLD;
            end
            ST_VLD: begin
               // Low byte arrives; core released with PC loaded
               pc_d[7:0] = vec_data_i;
               pc_ld_d   = 1'b1;
               cpu_rst_d = 1'b0;
               st_d      = ST_RUN;
            end
            default: begin
               // Unused codes fall back to run, still held in reset
               st_d = ST_RUN;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Cause flags
   // ------------------------------------------------------------
   // A set in the clearing cycle survives the read
   always @* begin
      if (por_ev) begin
         flags_d = `RSQ_CAUSE_POR;
      end else if (rd_clear) begin
         // Clear only what was handed out; a flag set after the
         // read data was latched stays for the next read
         flags_d = (flags_q & ~prdata_o[`RSQ_FLAGS_W-1:0]) | set_d;
      end else begin
         flags_d = flags_q | set_d;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (srst_i) begin
         // Idle high like the pin itself, so no false edge after reset
         pin_s_q        <= 3'h7;
         por_s_q        <= 3'h0;
         lsup_s_q       <= 3'h0;
         pin_lvl_q      <= 1'b1;
         por_lvl_q      <= 1'b0;
         lsup_lvl_q     <= 1'b0;
         st_q           <= ST_STAB;
         cnt_q          <= {`RSQ_CNT_W{1'b0}};
         flags_q        <= `RSQ_CAUSE_RST;
         stop_en_q      <= `RSQ_STOP_EN_RST;
         prdata_o       <= 32'h0000_0000;
         pready_o       <= 1'b0;
         pslverr_o      <= 1'b0;
         rst_pin_o      <= 1'b0;
         rst_pin_oe_o   <= 1'b1;
         wdog_clear_o   <= 1'b0;
         cpu_reset_o    <= 1'b1;
         clocks_hold_o  <= 1'b1;
         bus_div4_sel_o <= 1'b1;
         vec_rd_o       <= 1'b0;
         vec_addr_o     <= 16'h0000;
         pc_o           <= 16'h0000;
         pc_load_o      <= 1'b0;
      end else if (clk_en_i) begin
         pin_s_q    <= {pin_s_q[1:0], rst_pin_i};
         por_s_q    <= {por_s_q[1:0], power_on_pulse_i};
         lsup_s_q   <= {lsup_s_q[1:0], low_supply_i};
         pin_lvl_q  <= filt(pin_s_q[1], pin_s_q[2], pin_lvl_q);
         por_lvl_q  <= filt(por_s_q[1], por_s_q[2], por_lvl_q);
         lsup_lvl_q <= filt(lsup_s_q[1], lsup_s_q[2], lsup_lvl_q);
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         flags_q    <= flags_d;
         // Open drain: only ever pulls low
         rst_pin_o      <= 1'b0;
         rst_pin_oe_o   <= drive_d;
         cpu_reset_o    <= cpu_rst_d;
         clocks_hold_o  <= hold_d;
         bus_div4_sel_o <= cpu_rst_d;
         vec_rd_o       <= vec_rd_d;
         vec_addr_o     <= vec_addr_d;
         pc_o           <= pc_d;
         pc_load_o      <= pc_ld_d;
         // No clear while the core is held: it cannot be writing
         wdog_clear_o   <= ~cpu_rst_d & cpu_wr_i
                         & (cpu_addr_i == `RSQ_WDOG_ADDR);
         // APB: cause register ignores writes
         pready_o  <= apb_acc;
         if (apb_acc) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata_d;
            pslverr_o <= err_d;
         end else begin
            pslverr_o <= 1'b0;
         end
         if (apb_done && pwrite_i && paddr_i == `RSQ_OFS_CONFIG) begin
            stop_en_q <= pwdata_i[`RSQ_B_STOP_EN];
         end
      end
   end

endmodule

/* File: verification/rsq_top_props.sv */
// Concurrent checks on the reset sequencer ports.
// Assumes one clock domain and clk_en_i held high while sequences run.
`timescale 1ns/10ps
`include "rsq_defs.vh"
module rsq_top_props (
   input wire        ref_clk_i,
   input wire        srst_i,
   input wire        clk_en_i,
   input wire        rst_pin_i,
   input wire        rst_pin_oe_o,
   input wire        power_on_pulse_i,
   input wire        low_supply_i,
   input wire        wdog_overflow_i,
   input wire        bad_opcode_i,
   input wire        stop_exec_i,
   input wire        fetch_unmapped_i,
   input wire        fetch_is_opcode_i,
   input wire        monitor_entry_i,
   input wire        cpu_wr_i,
   input wire [15:0] cpu_addr_i,
   input wire        wdog_clear_o,
   input wire [7:0]  vec_data_i,
   input wire        cpu_reset_o,
   input wire        clocks_hold_o,
   input wire        bus_div4_sel_o,
   input wire        vec_rd_o,
   input wire [15:0] vec_addr_o,
   input wire [15:0] pc_o,
   input wire        pc_load_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);
   reg  [12:0] post_q;
   reg  [13:0] hold_q;
   wire        ev_any = wdog_overflow_i | bad_opcode_i | monitor_entry_i |
                        (fetch_unmapped_i & fetch_is_opcode_i);
   // ------------------------------------------------------------
   // Cycle counters for the long phases
   // ------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (srst_i || !rst_pin_oe_o)
         post_q <= 13'h0000;
      else if (!clocks_hold_o)
         post_q <= post_q + 13'h0001;
      if (srst_i || !clocks_hold_o)
         hold_q <= 14'h0000;
      else
         hold_q <= hold_q + 14'h0001;
   end
   sequence s_vec_fetch;
      (vec_rd_o && vec_addr_o == `RSQ_VEC_HI_ADDR) ##1
      (vec_rd_o && vec_addr_o == `RSQ_VEC_LO_ADDR) ##1 (pc_load_o && !cpu_reset_o);
   endsequence
   property p_start;
      ev_any && clk_en_i && !cpu_reset_o |=> cpu_reset_o && rst_pin_oe_o;
   endproperty
   a_start: assert property (p_start)
      else $error("event did not start a driven reset");
   property p_pin32;
      $fell(rst_pin_oe_o) |-> post_q == 13'h0020;
   endproperty
   a_pin32: assert property (p_pin32)
      else $error("pin drive length after stabilization wrong");
   property p_post;
      $fell(rst_pin_oe_o) |-> ##33 s_vec_fetch;
   endproperty
   a_post: assert property (p_post)
      else $error("vector fetch not 32 cycles after pin release");
   property p_pc;
      pc_load_o |-> pc_o == {$past(vec_data_i, 2), $past(vec_data_i, 1)};
   endproperty
   a_pc: assert property (p_pc)
      else $error("program counter not built from vector bytes");
   property p_div4;
      bus_div4_sel_o == cpu_reset_o;
   endproperty
   a_div4: assert property (p_div4)
      else $error("bus clock select differs from reset state");
   property p_stab;
      $fell(clocks_hold_o) |-> hold_q >= 14'h1000 && rst_pin_oe_o;
   endproperty
   a_stab: assert property (p_stab)
      else $error("stabilization delay too short");
   property p_hold;
      clocks_hold_o |-> rst_pin_oe_o && cpu_reset_o;
   endproperty
   a_hold: assert property (p_hold)
      else $error("clocks held without pin drive and core reset");
   property p_low;
      low_supply_i [*6] |-> clocks_hold_o && rst_pin_oe_o;
   endproperty
   a_low: assert property (p_low)
      else $error("low supply not holding reset");
   property p_wclr;
      cpu_wr_i && cpu_addr_i == `RSQ_WDOG_ADDR && clk_en_i && !cpu_reset_o |=> wdog_clear_o;
   endproperty
   a_wclr: assert property (p_wclr)
      else $error("watchdog clear missing");
   property p_data;
      fetch_unmapped_i && !fetch_is_opcode_i && !cpu_reset_o && !wdog_overflow_i &&
      !bad_opcode_i && !stop_exec_i && !monitor_entry_i && !low_supply_i &&
      !power_on_pulse_i && rst_pin_i |=> !cpu_reset_o;
   endproperty
   a_data: assert property (p_data)
      else $error("data fetch caused a reset");
endmodule
bind rsq_top rsq_top_props u_props (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i), .rst_pin_i(rst_pin_i),
   .rst_pin_oe_o(rst_pin_oe_o), .power_on_pulse_i(power_on_pulse_i),
   .low_supply_i(low_supply_i), .wdog_overflow_i(wdog_overflow_i),
   .bad_opcode_i(bad_opcode_i), .stop_exec_i(stop_exec_i),
   .fetch_unmapped_i(fetch_unmapped_i), .fetch_is_opcode_i(fetch_is_opcode_i),
   .monitor_entry_i(monitor_entry_i), .cpu_wr_i(cpu_wr_i), .cpu_addr_i(cpu_addr_i),
   .wdog_clear_o(wdog_clear_o), .vec_data_i(vec_data_i), .cpu_reset_o(cpu_reset_o),
   .clocks_hold_o(clocks_hold_o), .bus_div4_sel_o(bus_div4_sel_o), .vec_rd_o(vec_rd_o),
   .vec_addr_o(vec_addr_o), .pc_o(pc_o), .pc_load_o(pc_load_o));

/* File: verification/rsq_pin_model.sv */
// External device sharing the open-drain reset line, with pull-up.
// Assumes hold_low_i is driven on the reference clock by the bench.
`timescale 1ns/10ps
module rsq_pin_model #(
   parameter int MIN_LOW = 4
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_pin_o,
   input  wire logic rst_pin_oe_o,
   input  wire logic hold_low_i,
   output wire logic pin_o
);
   int   low_cnt = 0;
   logic pull_q  = 1'b0;
   // ------------------------------------------------------------
   // Requests are stretched so the line is never low too briefly
   // ------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (hold_low_i) begin
         pull_q <= 1'b1;
         low_cnt <= MIN_LOW;
      end else if (low_cnt > 0) begin
         low_cnt <= low_cnt - 1;
      end else begin
         pull_q <= 1'b0;
      end
   end
   // Pull-up wins once every party lets go
   assign pin_o = (rst_pin_oe_o ? rst_pin_o : 1'b1) & ~pull_q;
endmodule

/* File: verification/rsq_top_tb.sv */
// Self-checking bench for the reset sequencer and cause log.
// Assumes rsq_top, its checker and the pin model are compiled first.
`timescale 1ns/10ps
`include "rsq_defs.vh"
module rsq_top_tb;
   reg         ref_clk_i;
   reg         srst_i   = 1'b1;
   reg         psel_i   = 1'b0;
   reg         penable_i = 1'b0;
   reg         pwrite_i = 1'b0;
   reg  [11:0] paddr_i  = 12'h000;
   reg  [31:0] pwdata_i = 32'h00000000;
   reg  [5:0]  ev       = 6'h00;
   reg         power_on = 1'b0;
   reg         low_sup  = 1'b0;
   reg         hold_low = 1'b0;
   reg         cpu_wr   = 1'b0;
   reg         clk_en   = 1'b1;
   reg  [15:0] cpu_addr = 16'hFFFF;
   reg  [7:0]  vhi      = 8'h00;
   reg  [7:0]  vlo      = 8'h00;
   reg  [31:0] q;
   reg  [7:0]  acc;
   reg  [5:0]  e;
   reg         err;
   wire [31:0] prdata_o;
   wire [15:0] vec_addr_o;
   wire [15:0] pc_o;
   wire        pready_o, pslverr_o, pin, pin_o, pin_oe, wclr, cpu_reset_o, pc_load_o;
   integer     n_mismatch = 0;
   integer     compares = 0;
   integer     cyc = 0;
   integer     k;
   rsq_top DUT (
      .ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .rst_pin_i(pin), .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe),
      .power_on_pulse_i(power_on), .low_supply_i(low_sup),
      .wdog_overflow_i(ev[0]), .bad_opcode_i(ev[1]), .stop_exec_i(ev[2]),
      .fetch_unmapped_i(ev[3]), .fetch_is_opcode_i(ev[4]), .monitor_entry_i(ev[5]),
      .cpu_wr_i(cpu_wr), .cpu_addr_i(cpu_addr), .wdog_clear_o(wclr),
      .vec_data_i(vec_addr_o[0] ? vlo : vhi), .cpu_reset_o(cpu_reset_o),
      .clocks_hold_o(), .bus_div4_sel_o(), .vec_rd_o(), .vec_addr_o(vec_addr_o),
      .pc_o(pc_o), .pc_load_o(pc_load_o));
   rsq_pin_model #(.MIN_LOW(4)) u_pin (.ref_clk_i(ref_clk_i), .rst_pin_o(pin_o),
      .rst_pin_oe_o(pin_oe), .hold_low_i(hold_low), .pin_o(pin));
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task chk(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // ------------------------------------------------------------
   // Bus and sequence helpers
   // ------------------------------------------------------------
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge ref_clk_i);
         psel_i <= 1'b1;
         pwrite_i <= wr;
         paddr_i <= a;
         pwdata_i <= d;
         @(posedge ref_clk_i);
         penable_i <= 1'b1;
         @(posedge ref_clk_i);
         while (pready_o !== 1'b1)
            @(posedge ref_clk_i);
         q = prdata_o;
         err = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask
   task pulse(input [5:0] c);
      begin
         @(posedge ref_clk_i);
         ev <= c;
         vhi <= $urandom;
         vlo <= $urandom;
         @(posedge ref_clk_i);
         ev <= 6'h00;
      end
   endtask
   task wait_pc(input integer lim);
      integer n;
      begin
         n = 0;
         while (pc_load_o !== 1'b1 && n < lim) begin
            @(posedge ref_clk_i);
            n = n + 1;
         end
         chk({31'h0, pc_load_o}, 32'h1, "pc_load");
         chk({16'h0, pc_o}, {16'h0, vhi, vlo}, "pc");
      end
   endtask
   function [7:0] exp_flag(input [5:0] c);
      begin
         exp_flag = 8'h00;
         exp_flag[`RSQ_B_WATCHDOG] = c[0];
         exp_flag[`RSQ_B_BAD_OP] = c[1] | c[2];
         exp_flag[`RSQ_B_BAD_FETCH] = c[3] & c[4];
         exp_flag[`RSQ_B_MONITOR] = c[5];
      end
   endfunction
   always @(posedge ref_clk_i) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up;
      end
   end
   initial begin
      void'($urandom(32'h2A1B));
      vhi = $urandom;
      vlo = $urandom;
      repeat (8) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      wait_pc(5000);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, {24'h0, `RSQ_CAUSE_POR}, "cause_por");
      apb(1'b1, `RSQ_OFS_CAUSE, 32'hFF);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, 32'h0, "cause_clr");
      apb(1'b0, 12'hFFC, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped");
      apb(1'b0, `RSQ_OFS_CONFIG, 32'h0);
      chk(q, 32'h0, "cfg_rst");
      apb(1'b0, `RSQ_OFS_STATUS, 32'h0);
      chk(q, 32'h10, "status");
      acc = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
         q = (k < 5) ? k : $urandom % 5;
         e = (q == 4) ? 6'h20 : (q == 3) ? 6'h18 : (6'h01 << q[1:0]);
         acc = acc | exp_flag(e);
         pulse(e);
         wait_pc(200);
      end
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, {24'h0, acc}, "cause_acc");
      apb(1'b1, `RSQ_OFS_CONFIG, 32'h1);
      pulse(6'h08);
      pulse(6'h0C);
      repeat (4) @(posedge ref_clk_i);
      chk({31'h0, cpu_reset_o}, 32'h0, "no_reset");
      clk_en <= 1'b0;
      pulse(6'h01);
      repeat (2) @(posedge ref_clk_i);
      chk({31'h0, cpu_reset_o}, 32'h0, "frozen");
      clk_en <= 1'b1;
      apb(1'b1, `RSQ_OFS_CONFIG, 32'h0);
      @(posedge ref_clk_i);
      cpu_wr   <= 1'b1;
      cpu_addr <= 16'($urandom % 32'hFFFF);
      @(posedge ref_clk_i);
      cpu_addr <= 16'hFFFF;
      @(posedge ref_clk_i);
      cpu_wr   <= 1'b0;
      chk({31'h0, wclr}, 32'h0, "wdog_other");
      @(posedge ref_clk_i);
      chk({31'h0, wclr}, 32'h1, "wdog_clr");
      hold_low <= 1'b1;
      repeat (10 + $urandom % 30) @(posedge ref_clk_i);
      hold_low <= 1'b0;
      wait_pc(200);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, 32'h40, "cause_ext");
      pulse(6'h20);
      hold_low <= 1'b1;
      wait_pc(200);
      hold_low <= 1'b0;
      repeat (80) @(posedge ref_clk_i);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, 32'h44, "cause_late");
      pulse(6'h01);
      wait_pc(200);
      power_on <= 1'b1;
      repeat (10) @(posedge ref_clk_i);
      power_on <= 1'b0;
      wait_pc(5000);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, 32'h80, "cause_pwr");
      low_sup <= 1'b1;
      repeat (20) @(posedge ref_clk_i);
      low_sup <= 1'b0;
      wait_pc(5000);
      apb(1'b0, `RSQ_OFS_CAUSE, 32'h0);
      chk(q, 32'h02, "cause_low");
      wrap_up;
   end
endmodule
